// File: hw/ebted_pkg.sv
// Purpose: Shared constants and types of the eight-bit timer, event counter and divider.
// Assumes: APB register slave with 32-bit data, one aligned word per register.
// Notes:   All offsets are byte addresses.
package ebted_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  OFF_CTRL       = 8'h00;
   localparam logic [7:0]  OFF_COMPARE    = 8'h04;
   localparam logic [7:0]  OFF_COMPANION  = 8'h08;
   localparam logic [7:0]  OFF_STATE      = 8'h0C;
   localparam logic [7:0]  OFF_INT_STATUS = 8'h10;
   localparam logic [7:0]  OFF_INT_MASK   = 8'h14;

   // ---------------------------------------------------------------
   // Field positions of channel_control_register and the companion, state and interrupt registers
   // ---------------------------------------------------------------
   localparam int BIT_START      = 0;
   localparam int BIT_MODE_LO    = 1;
   localparam int BIT_CLK_LO     = 3;
   localparam int BIT_FF_INIT    = 5;
   localparam int BIT_DIV_SEL    = 6;
   localparam int BIT_SLOW       = 7;
   localparam int BIT_OUT_DIS    = 0;
   localparam int BIT_STATE_FF   = 8;
   localparam int BIT_MATCH      = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CTRL      = 8'h00;
   localparam logic [7:0] RST_COMPARE   = 8'h00;
   localparam logic       RST_OUT_DIS   = 1'h0;
   localparam logic       RST_INT_MASK  = 1'h0;

   // ---------------------------------------------------------------
   // Prescaler taps as powers of two of the fast clock
   // ---------------------------------------------------------------
   localparam int PRE_W     = 11;
   localparam int TAP_SLOW  = 11;
   localparam int TAP_MID   = 7;
   localparam int TAP_FAST  = 5;
   localparam int TAP_TOP   = 3;
   localparam int FS_DIV_W  = 3;

   typedef enum logic [1:0] {
      EBTED_MODE_TIMER  = 2'h0,
      EBTED_MODE_EVENT  = 2'h1,
      EBTED_MODE_DIVIDE = 2'h2
   } ebted_mode_t;

   typedef enum logic [1:0] {
      EBTED_CLK_SLOWEST = 2'h0,
      EBTED_CLK_MID     = 2'h1,
      EBTED_CLK_FAST    = 2'h2,
      EBTED_CLK_TOP     = 2'h3
   } ebted_clk_t;

endpackage : ebted_pkg

// File: hw/ebted_edge_if.sv
// Purpose: Carries a synchronised pin level and its edge pulses.
// Assumes: Single clock domain on the receiving side.
// Notes:   Pulses last one sys_clk cycle.
`timescale 1ns/1ns
interface ebted_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : ebted_edge_if

// File: hw/ebted_edge_sync.sv
// Purpose: Two-stage synchroniser with edge detection for an asynchronous pin.
// Assumes: The pin holds each level for at least two sys_clk cycles.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
module ebted_edge_sync
(
   // Clock and reset
   input  logic       sys_clk,
   input  logic       sys_rst,
   // Pin and edges
   input  logic       pin,
   ebted_edge_if.src  edge_o
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } ebted_sync_t;

   ebted_sync_t state;
   ebted_sync_t next_state;

   always_comb
   begin
      next_state      = state;
      next_state.meta = pin;
      next_state.sync = state.meta;
      next_state.last = state.sync;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state <= '0;
      else
         state <= next_state;
   end

   assign edge_o.level = state.sync;
   assign edge_o.rise  = state.sync & ~state.last;
   assign edge_o.fall  = ~state.sync & state.last;

endmodule : ebted_edge_sync

// File: hw/ebted_timer.sv
// Purpose: Eight-bit timer channel with timer, event counter and divider output modes.
// Assumes: sys_clk is the fast clock fc; lf_clk_pin carries the slow clock fs.
// Notes:   Registers are reached over APB with zero wait states.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ns

// Operation
// R1: Timer mode counts ticks, match clears, interrupts.
// R2: Event and divider modes only on second channel.
// R3: Software keeps flip-flop initial bit zero.
// R4: Compare register has no shadow stage.
// R5: Software avoids compare rewrites while timing.
// R6: Clock selectable; slow operation uses fs/8 only.
// R7: Event mode counts falling edges of pin.
// R8: Event match interrupts, clears, keeps counting.
// R9: Event pin levels last two machine cycles.
// R10: Divider mode gives fifty percent square wave.
// R11: Divider match toggles flip-flop, clears, interrupts.
// R12: Divider pin drives inverse of flip-flop.
// R13: Initial bit loads flip-flop; reset clears it.
// R14: Software enables port latch for divider output.
// R15: Software changes mode fields only when starting.
// R16: Output-disable bit suppresses pin pulses.
// R17: Stopped divider holds flip-flop state.
// R18: Match interrupt is one-cycle pulse.
module ebted_timer
#(
   parameter int CNT_W          = 8,
   parameter bit SECOND_CHANNEL = 1'b1
)
(
   // Clock and reset
   input  logic                          sys_clk,
   input  logic                          sys_rst,
   // APB slave
   input  logic                          psel,
   input  logic                          penable,
   input  logic                          pwrite,
   input  logic [ebted_pkg::ADDR_W-1:0]  paddr,
   input  logic [31:0]                   pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Pins
   input  logic                          event_input_pin,
   input  logic                          lf_clk_pin,
   output logic                          divider_output_pin,
   // Interrupts
   output logic                          match_interrupt,
   output logic                          irq
);

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   if (CNT_W < 2 || CNT_W > 16)
   begin : g_bad_width
      $error("ebted_timer: CNT_W must lie between 2 and 16.");
   end

   typedef struct packed {
      logic                            run;
      logic [1:0]                      mode;
      logic [1:0]                      clk_sel;
      logic                            ff_init;
      logic                            div_sel;
      logic                            slow;
      logic [CNT_W-1:0]                cmp;
      logic                            out_dis;
      logic [CNT_W-1:0]                cnt;
      logic                            ff;
      logic [ebted_pkg::PRE_W-1:0]     pre;
      logic [ebted_pkg::FS_DIV_W-1:0]  fs_div;
      logic                            stat;
      logic                            mask;
      logic                            pulse;
      logic [31:0]                     rdata;
   } ebted_state_t;

   ebted_state_t state;
   ebted_state_t next_state;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   ebted_edge_if ev_if ();
   ebted_edge_if lf_if ();

   ebted_edge_sync u_ev_sync
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     (event_input_pin),
      .edge_o  (ev_if.src)
   );

   ebted_edge_sync u_lf_sync
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     (lf_clk_pin),
      .edge_o  (lf_if.src)
   );

   // ---------------------------------------------------------------
   // Bus decode and clock sources
   // ---------------------------------------------------------------
   logic             setup;
   logic             wr;
   logic             mapped;
   logic             ctrl_wr;
   logic             cmp_wr;
   logic             tick_fs;
   logic             tick_int;
   logic             tick;
   logic             match;
   logic [1:0]       mode_eff;
   logic [CNT_W-1:0] cnt_inc;

   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign mapped  = (paddr == ebted_pkg::OFF_CTRL) || (paddr == ebted_pkg::OFF_COMPARE)
                 || (paddr == ebted_pkg::OFF_COMPANION) || (paddr == ebted_pkg::OFF_STATE)
                 || (paddr == ebted_pkg::OFF_INT_STATUS) || (paddr == ebted_pkg::OFF_INT_MASK);
   assign ctrl_wr = wr && (paddr == ebted_pkg::OFF_CTRL);
   assign cmp_wr  = wr && (paddr == ebted_pkg::OFF_COMPARE);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // The slow clock fs is divided by eight before use.
   assign tick_fs = lf_if.rise & (&state.fs_div);

   // Channels without the extra modes fall back to timer mode.
   assign mode_eff = (SECOND_CHANNEL || state.mode == ebted_pkg::EBTED_MODE_TIMER) ? state.mode
                   : ebted_pkg::EBTED_MODE_TIMER; // R2

   always_comb
   begin
      if (state.slow)
         tick_int = tick_fs; // R6
      else
      begin
         case (state.clk_sel)
            ebted_pkg::EBTED_CLK_SLOWEST:
               tick_int = state.div_sel ? tick_fs : &state.pre[ebted_pkg::TAP_SLOW-1:0]; // R6
            ebted_pkg::EBTED_CLK_MID:  tick_int = &state.pre[ebted_pkg::TAP_MID-1:0];
            ebted_pkg::EBTED_CLK_FAST: tick_int = &state.pre[ebted_pkg::TAP_FAST-1:0];
            ebted_pkg::EBTED_CLK_TOP:  tick_int = &state.pre[ebted_pkg::TAP_TOP-1:0];
            default:                   tick_int = 1'b0;
         endcase
      end
   end

   assign tick    = state.run & ((mode_eff == ebted_pkg::EBTED_MODE_EVENT) ? ev_if.fall
                                                                           : tick_int); // R7
   assign cnt_inc = state.cnt + 1'b1;
   assign match   = tick && (cnt_inc == state.cmp);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_state        = state;
      next_state.pre    = state.pre + 1'b1;
      next_state.pulse  = match; // R18
      if (lf_if.rise)
         next_state.fs_div = state.fs_div + 1'b1;

      if (!state.run)
         next_state.cnt = '0; // R17
      else if (match)
      begin
         next_state.cnt = '0; // R1 R8
         if (mode_eff == ebted_pkg::EBTED_MODE_DIVIDE)
            next_state.ff = ~state.ff; // R10 R11
      end
      else if (tick)
         next_state.cnt = cnt_inc; // R1 R7

      // A new event wins over a clear in the same cycle.
      next_state.stat = state.stat | match;
      if (wr && paddr == ebted_pkg::OFF_INT_STATUS && pwdata[ebted_pkg::BIT_MATCH])
         next_state.stat = match;

      if (ctrl_wr)
      begin
         next_state.run     = pwdata[ebted_pkg::BIT_START];
         next_state.mode    = pwdata[ebted_pkg::BIT_MODE_LO +: 2];
         next_state.clk_sel = pwdata[ebted_pkg::BIT_CLK_LO +: 2];
         next_state.ff_init = pwdata[ebted_pkg::BIT_FF_INIT];
         next_state.div_sel = pwdata[ebted_pkg::BIT_DIV_SEL];
         next_state.slow    = pwdata[ebted_pkg::BIT_SLOW];
         // A stop write leaves the flip-flop alone so the pin keeps its last level.
         if (!state.run)
            next_state.ff   = pwdata[ebted_pkg::BIT_FF_INIT]; // R13 R17
      end
      if (cmp_wr)
         next_state.cmp = pwdata[CNT_W-1:0]; // R4
      if (wr && paddr == ebted_pkg::OFF_COMPANION)
         next_state.out_dis = pwdata[ebted_pkg::BIT_OUT_DIS];
      if (wr && paddr == ebted_pkg::OFF_INT_MASK)
         next_state.mask = pwdata[ebted_pkg::BIT_MATCH];

      if (setup && !pwrite)
      begin
         case (paddr)
            ebted_pkg::OFF_CTRL:
               next_state.rdata = {24'h000000, state.slow, state.div_sel, state.ff_init,
                                   state.clk_sel, state.mode, state.run};
            ebted_pkg::OFF_COMPARE:    next_state.rdata = 32'(state.cmp);
            ebted_pkg::OFF_COMPANION:  next_state.rdata = {31'h00000000, state.out_dis};
            ebted_pkg::OFF_STATE:
               next_state.rdata = {23'h000000, state.ff, 8'(state.cnt)};
            ebted_pkg::OFF_INT_STATUS: next_state.rdata = {31'h00000000, state.stat};
            ebted_pkg::OFF_INT_MASK:   next_state.rdata = {31'h00000000, state.mask};
            default:                   next_state.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state         <= '0; // R13
         state.cmp     <= CNT_W'(ebted_pkg::RST_COMPARE);
         state.out_dis <= ebted_pkg::RST_OUT_DIS;
         state.mask    <= ebted_pkg::RST_INT_MASK;
      end
      else
         state <= next_state;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata             = state.rdata;
   assign divider_output_pin = state.out_dis | ~state.ff; // R12 R16
   assign match_interrupt    = state.pulse; // R18
   assign irq                = state.stat & state.mask;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   chk_match_clears: assert property (match |=> state.cnt == '0 && match_interrupt) // R1
      else $error("Counter not cleared or no pulse after match.");

   chk_mode_fallback: assert property (!SECOND_CHANNEL |-> mode_eff == 2'h0) // R2
      else $error("Extra mode active on a first channel.");

   chk_cmp_immediate: assert property (cmp_wr |=> state.cmp == $past(pwdata[CNT_W-1:0])) // R4
      else $error("Compare write did not take effect at once.");

   chk_slow_source: assert property (state.run && state.slow && !tick_fs && !ctrl_wr
                                     && mode_eff != 2'h1 |=> $stable(state.cnt)) // R6
      else $error("Counter moved without a slow clock tick.");

   chk_event_count: assert property (state.run && mode_eff == 2'h1 && !ctrl_wr
                                     && !ev_if.fall |=> $stable(state.cnt)) // R7
      else $error("Event counter moved without a falling edge.");

   chk_event_step: assert property (tick && !match && mode_eff == 2'h1 && !ctrl_wr
                                    |=> state.cnt == $past(state.cnt) + 1'b1) // R8
      else $error("Event counter did not advance by one.");

   chk_divider_toggle: assert property (match && mode_eff == 2'h2 && !ctrl_wr
                                        |=> state.ff != $past(state.ff)) // R11
      else $error("Divider flip-flop did not toggle on match.");

   chk_pin_inverse: assert property (!state.out_dis |-> divider_output_pin == !state.ff) // R12
      else $error("Divider pin is not the inverse of the flip-flop.");

   chk_ff_load: assert property (ctrl_wr && !state.run
                                 |=> state.ff == $past(pwdata[ebted_pkg::BIT_FF_INIT])) // R13
      else $error("Initial bit not loaded into the flip-flop.");

   chk_pin_disable: assert property (state.out_dis |-> divider_output_pin) // R16
      else $error("Pulses reach the pin while output is disabled.");

   chk_stop_hold: assert property (!state.run && !ctrl_wr |=> $stable(state.ff)
                                   && state.cnt == '0) // R17
      else $error("Stopped channel changed its flip-flop.");

   chk_pulse_single: assert property (match_interrupt |=> !match_interrupt) // R18
      else $error("Match interrupt lasted more than one cycle.");

   cov_divider_match: cover property (match && mode_eff == 2'h2);
   cov_event_match:   cover property (match && mode_eff == 2'h1);
   cov_clear_and_set: cover property (match && wr && paddr == ebted_pkg::OFF_INT_STATUS);
   cov_bad_address:   cover property (pslverr);

endmodule : ebted_timer

// File: sim/ebted_timer_tb.sv
// Purpose: Self-checking bench for the eight-bit timer, event counter and divider.
// Assumes: Zero-wait APB slave; lf_clk_pin is made here at one sixth of sys_clk.
// Notes:   Periods are measured between match pulses, so prescaler phase is irrelevant.
`timescale 1ns/1ns
module ebted_timer_tb;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        event_input_pin = 1'b1;
   logic        lf_clk_pin = 1'b0;
   logic        divider_output_pin;
   logic        match_interrupt;
   logic        irq;
   int          bad_count = 0;
   int          checks = 0;
   int          cycles = 0;
   int          pulses = 0;
   int          lf_div = 0;
   int          m_ctrl = 0, m_cmp = 0, m_dis = 0, m_cnt = 0, m_ff = 0, m_stat = 0, m_mask = 0;
   int          cmp, p, h, h1, k, n, p0;
   logic [7:0]  ctl_tab [6] = '{8'h19, 8'h11, 8'h09, 8'h01, 8'h41, 8'h99};

   ebted_timer i_dut
   (
      .sys_clk            (sys_clk),
      .sys_rst            (sys_rst),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .paddr              (paddr),
      .pwdata             (pwdata),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .event_input_pin    (event_input_pin),
      .lf_clk_pin         (lf_clk_pin),
      .divider_output_pin (divider_output_pin),
      .match_interrupt    (match_interrupt),
      .irq                (irq)
   );

   always #10 sys_clk = ~sys_clk;

   // ---------------------------------------------------------------
   // Slow clock, pulse count and run limit
   // ---------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      cycles = cycles + 1;
      if (match_interrupt === 1'b1)
         pulses = pulses + 1;
      lf_div = (lf_div == 2) ? 0 : lf_div + 1;
      if (lf_div == 0)
         lf_clk_pin <= ~lf_clk_pin;
      if (cycles == 90000)
      begin
         bad_count = bad_count + 1;
         finish_test();
      end
   end

   task finish_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   task check(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // ---------------------------------------------------------------
   // Register model and APB master
   // ---------------------------------------------------------------
   function automatic logic [31:0] mdl_read(input logic [7:0] a);
      case (a)
         ebted_pkg::OFF_CTRL       : return m_ctrl;
         ebted_pkg::OFF_COMPARE    : return m_cmp;
         ebted_pkg::OFF_COMPANION  : return m_dis;
         ebted_pkg::OFF_STATE      : return (m_ff << 8) | m_cnt;
         ebted_pkg::OFF_INT_STATUS : return m_stat;
         ebted_pkg::OFF_INT_MASK   : return m_mask;
         default                   : return 32'h0;
      endcase
   endfunction : mdl_read

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
            output logic e);
      int w;
      w = 0;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         w = w + 1;
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task mwr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      case (a)
         ebted_pkg::OFF_CTRL       : begin if (!m_ctrl[0]) m_ff = d[5]; m_ctrl = d[7:0]; m_cnt = 0; end
         ebted_pkg::OFF_COMPARE    : m_cmp = d[7:0];
         ebted_pkg::OFF_COMPANION  : m_dis = d[0];
         ebted_pkg::OFF_INT_STATUS : if (d[0]) m_stat = 0;
         ebted_pkg::OFF_INT_MASK   : m_mask = d[0];
         default                   : ;
      endcase
   endtask : mwr

   task rd(input logic [7:0] a);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, mdl_read(a));
      check({31'h0, e}, {31'h0, (a > 8'h14)});
   endtask : rd

   task measure(output int q);
      int w;
      w = 0;
      while (match_interrupt !== 1'b1 && w < 30000)
      begin
         @(posedge sys_clk);
         w = w + 1;
      end
      @(posedge sys_clk);
      check({31'h0, match_interrupt}, 32'h0);
      q = 1;
      while (match_interrupt !== 1'b1 && q < 30000)
      begin
         @(posedge sys_clk);
         q = q + 1;
      end
   endtask : measure

   task half_len(output int q);
      logic l;
      l = divider_output_pin;
      q = 0;
      do
      begin
         @(posedge sys_clk);
         q = q + 1;
      end
      while (divider_output_pin === l && q < 30000);
   endtask : half_len

   function automatic int tick_of(input logic [7:0] c);
      if (c[7] || (c[4:3] == 2'h0 && c[6]))
         return 48;
      return 1 << ((c[4:3] == 2'h0) ? 11 : (c[4:3] == 2'h1) ? 7 : (c[4:3] == 2'h2) ? 5 : 3);
   endfunction : tick_of

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(30));
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a <= 32; a += 4) rd(a[7:0]);
      check({31'h0, divider_output_pin}, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         cmp = (i == 0) ? 255 : (i == 1) ? 1 : $urandom_range(2, 4);
         mwr(ebted_pkg::OFF_COMPARE, cmp);
         mwr(ebted_pkg::OFF_CTRL, ctl_tab[i]);
         measure(p);
         check(p, cmp * tick_of(ctl_tab[i]));
         mwr(ebted_pkg::OFF_CTRL, 32'(ctl_tab[i] & 8'hFE));
         m_stat = 1;
         rd(ebted_pkg::OFF_STATE);
      end
      cmp = $urandom_range(2, 6);
      mwr(ebted_pkg::OFF_COMPARE, cmp);
      mwr(ebted_pkg::OFF_CTRL, 32'h1D);
      half_len(h);
      half_len(h);
      half_len(h1);
      check(h, cmp * 8);
      check(h1, cmp * 8);
      mwr(ebted_pkg::OFF_COMPANION, 32'h1);
      n = 0;
      repeat (cmp * 24) @(posedge sys_clk) n += (divider_output_pin !== 1'b1);
      check(n, 0);
      mwr(ebted_pkg::OFF_COMPANION, 32'h0);
      mwr(ebted_pkg::OFF_CTRL, 32'h1C);
      k = divider_output_pin;
      n = 0;
      repeat (cmp * 24) @(posedge sys_clk) n += (divider_output_pin !== k[0]);
      check(n, 0);
      mwr(ebted_pkg::OFF_CTRL, 32'h24);
      n = 0;
      repeat (cmp * 24) @(posedge sys_clk) n += (divider_output_pin !== 1'b0);
      check(n, 0);
      rd(ebted_pkg::OFF_STATE);
      mwr(ebted_pkg::OFF_CTRL, 32'h04);
      @(posedge sys_clk);
      check({31'h0, divider_output_pin}, 32'h1);
      cmp = $urandom_range(2, 5);
      mwr(ebted_pkg::OFF_COMPARE, cmp);
      mwr(ebted_pkg::OFF_CTRL, 32'h03);
      n = 3 * cmp + $urandom_range(0, cmp - 1);
      p0 = pulses;
      for (int i = 0; i < n; i++)
      begin
         k = $urandom_range(3, 6);
         event_input_pin <= 1'b0;
         repeat (k) @(posedge sys_clk);
         event_input_pin <= 1'b1;
         repeat (9 - k) @(posedge sys_clk);
      end
      repeat (10) @(posedge sys_clk);
      check(pulses - p0, n / cmp);
      m_cnt = n % cmp;
      rd(ebted_pkg::OFF_STATE);
      mwr(ebted_pkg::OFF_CTRL, 32'h02);
      rd(ebted_pkg::OFF_INT_STATUS);
      check({31'h0, irq}, 32'h0);
      mwr(ebted_pkg::OFF_INT_MASK, 32'h1);
      @(posedge sys_clk);
      check({31'h0, irq}, 32'h1);
      mwr(ebted_pkg::OFF_INT_STATUS, 32'h1);
      @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      mwr(ebted_pkg::OFF_STATE, 32'hFFFF);
      for (int a = 0; a <= 32; a += 4) rd(a[7:0]);
      finish_test();
   end
endmodule : ebted_timer_tb
